// >>> src/apgr_pkg.sv
/*
 * package for the record-path gain and mix select register bank:
 * register offsets, field positions, reset values and code limits.
 * assumes an 8-bit register port with byte-wide offsets.
 */
package apgr_pkg;
    // register offsets
    localparam logic [7:0] APGR_LEFT_GAIN_OFS  = 8'h0F;
    localparam logic [7:0] APGR_RIGHT_GAIN_OFS = 8'h10;
    localparam logic [7:0] APGR_MIC3_LEFT_OFS  = 8'h11;
    localparam logic [7:0] APGR_MIC3_RIGHT_OFS = 8'h12;
    // field positions
    localparam int APGR_MUTE_BIT   = 7;
    localparam int APGR_GAIN_MSB   = 6;
    localparam int APGR_UPPER_LSB  = 4;
    localparam int APGR_LOWER_MSB  = 3;
    // reset values
    localparam logic [7:0] APGR_GAIN_RESET = 8'h80;
    localparam logic [7:0] APGR_MIX_RESET  = 8'hFF;
    // code limits
    localparam logic [6:0] APGR_GAIN_MAX   = 7'h77;
    localparam logic [3:0] APGR_LEVEL_MAX  = 4'h8;
    localparam logic [3:0] APGR_LEVEL_OFF  = 4'hF;
endpackage : apgr_pkg

// >>> src/apgr_regs.sv
/*
 * register bank holding record pga mute/gain and third-mic mix levels,
 * decoded into registered control outputs for the analog record path.
 * assumes a same-clock register port: one-cycle write strobe, read data
 * registered one cycle after the read strobe.
 */
// Operation
// - left pga mute bit resets set
// - right pga mute bit resets set
// - left gain code, half dB steps
// - decoded gain saturates at 59.5 dB
// - right gain code, same decoding
// - third mic left into left mix
// - third mic right into left mix
// - third mic left into right mix
// - third mic right into right mix
// - valid level connects, 1111 disconnects
`timescale 1ns/10ps
`default_nettype none
module apgr_regs
    import apgr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    output logic            left_mute_out,
    output logic            right_mute_out,
    output logic      [6:0] left_gain_out,
    output logic      [6:0] right_gain_out,
    output logic      [3:0] third_mic_left_input_left_lvl_out,
    output logic      [3:0] third_mic_right_input_left_lvl_out,
    output logic      [3:0] third_mic_left_input_right_lvl_out,
    output logic      [3:0] third_mic_right_input_right_lvl_out,
    output logic      [3:0] mix_connect_out
);

////////////////////////////////////////////////////////////////////////////////

typedef struct packed {
    logic [7:0] left_record_gain_ctrl;
    logic [7:0] right_record_gain_ctrl;
    logic [7:0] mic_three_to_left_mix;
    logic [7:0] mic_three_to_right_mix;
    logic [7:0] rdata;
    logic [6:0] left_gain;
    logic [6:0] right_gain;
    logic [3:0] connect;
} apgr_state_t;

apgr_state_t state_reg;
apgr_state_t state_next;

function automatic logic [6:0] apgr_sat(input logic [6:0] code);
    apgr_sat = (code > APGR_GAIN_MAX) ? APGR_GAIN_MAX : code;
endfunction : apgr_sat

function automatic logic apgr_conn(input logic [3:0] lvl);
    // reserved codes leave the input connected; undefined gain anyway
    apgr_conn = (lvl != APGR_LEVEL_OFF);
endfunction : apgr_conn

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    state_next = state_reg;
    if (wr_en_in) begin
        case (addr_in)
            APGR_LEFT_GAIN_OFS:  state_next.left_record_gain_ctrl  = wdata_in;
            APGR_RIGHT_GAIN_OFS: state_next.right_record_gain_ctrl = wdata_in;
            APGR_MIC3_LEFT_OFS:  state_next.mic_three_to_left_mix  = wdata_in;
            APGR_MIC3_RIGHT_OFS: state_next.mic_three_to_right_mix = wdata_in;
            default: ;
        endcase
    end
    if (rd_en_in) begin
        case (addr_in)
            APGR_LEFT_GAIN_OFS:  state_next.rdata = state_reg.left_record_gain_ctrl;
            APGR_RIGHT_GAIN_OFS: state_next.rdata = state_reg.right_record_gain_ctrl;
            APGR_MIC3_LEFT_OFS:  state_next.rdata = state_reg.mic_three_to_left_mix;
            APGR_MIC3_RIGHT_OFS: state_next.rdata = state_reg.mic_three_to_right_mix;
            default:             state_next.rdata = 8'h00;
        endcase
    end
    // decoded gains, half dB per code
    state_next.left_gain  = apgr_sat(state_next.left_record_gain_ctrl[APGR_GAIN_MSB:0]);
    state_next.right_gain = apgr_sat(state_next.right_record_gain_ctrl[APGR_GAIN_MSB:0]);
    state_next.connect = {apgr_conn(state_next.mic_three_to_right_mix[APGR_LOWER_MSB:0]),
                          apgr_conn(state_next.mic_three_to_right_mix[7:APGR_UPPER_LSB]),
                          apgr_conn(state_next.mic_three_to_left_mix[APGR_LOWER_MSB:0]),
                          apgr_conn(state_next.mic_three_to_left_mix[7:APGR_UPPER_LSB])};
end

always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
        state_reg.left_record_gain_ctrl  <= APGR_GAIN_RESET;
        state_reg.right_record_gain_ctrl <= APGR_GAIN_RESET;
        state_reg.mic_three_to_left_mix  <= APGR_MIX_RESET;
        state_reg.mic_three_to_right_mix <= APGR_MIX_RESET;
        state_reg.rdata                  <= 8'h00;
        state_reg.left_gain              <= 7'h00;
        state_reg.right_gain             <= 7'h00;
        state_reg.connect                <= 4'h0;
    end else begin
        state_reg <= state_next;
    end
end

////////////////////////////////////////////////////////////////////////////////

assign left_mute_out  = state_reg.left_record_gain_ctrl[APGR_MUTE_BIT];
assign right_mute_out = state_reg.right_record_gain_ctrl[APGR_MUTE_BIT];
assign left_gain_out  = state_reg.left_gain;
assign right_gain_out = state_reg.right_gain;
assign third_mic_left_input_left_lvl_out   = state_reg.mic_three_to_left_mix[7:APGR_UPPER_LSB];
assign third_mic_right_input_left_lvl_out  = state_reg.mic_three_to_left_mix[APGR_LOWER_MSB:0];
assign third_mic_left_input_right_lvl_out  = state_reg.mic_three_to_right_mix[7:APGR_UPPER_LSB];
assign third_mic_right_input_right_lvl_out = state_reg.mic_three_to_right_mix[APGR_LOWER_MSB:0];
assign mix_connect_out = state_reg.connect;
assign rdata_out       = state_reg.rdata;

////////////////////////////////////////////////////////////////////////////////

chk_left_mute_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_LEFT_GAIN_OFS |=> left_mute_out == $past(wdata_in[7]))
    else $error("left mute not taken from write");
chk_right_mute_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_RIGHT_GAIN_OFS |=> right_mute_out == $past(wdata_in[7]))
    else $error("right mute not taken from write");
chk_left_gain_pass: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_LEFT_GAIN_OFS && wdata_in[6:0] <= 7'h77
    |=> left_gain_out == $past(wdata_in[6:0]))
    else $error("left gain code not passed through");
chk_gain_saturate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    left_gain_out <= 7'h77 && right_gain_out <= 7'h77)
    else $error("gain above 59.5 dB");
chk_right_gain_sat: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_RIGHT_GAIN_OFS && wdata_in[6:0] > 7'h77
    |=> right_gain_out == 7'h77)
    else $error("right gain not saturated");
chk_left_mix_upper: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_MIC3_LEFT_OFS
    |=> third_mic_left_input_left_lvl_out == $past(wdata_in[7:APGR_UPPER_LSB]))
    else $error("left mix upper nibble wrong");
chk_left_mix_lower: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_MIC3_LEFT_OFS
    |=> third_mic_right_input_left_lvl_out == $past(wdata_in[APGR_LOWER_MSB:0]))
    else $error("left mix lower nibble wrong");
chk_right_mix_upper: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_MIC3_RIGHT_OFS
    |=> third_mic_left_input_right_lvl_out == $past(wdata_in[7:APGR_UPPER_LSB]))
    else $error("right mix upper nibble wrong");
chk_right_mix_lower: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_MIC3_RIGHT_OFS
    |=> third_mic_right_input_right_lvl_out == $past(wdata_in[APGR_LOWER_MSB:0]))
    else $error("right mix lower nibble wrong");
chk_mix_connect: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mix_connect_out == {third_mic_right_input_right_lvl_out != APGR_LEVEL_OFF,
                        third_mic_left_input_right_lvl_out != APGR_LEVEL_OFF,
                        third_mic_right_input_left_lvl_out != APGR_LEVEL_OFF,
                        third_mic_left_input_left_lvl_out != APGR_LEVEL_OFF})
    else $error("mix connect disagrees with level");
chk_read_back: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_en_in && !wr_en_in && addr_in == APGR_MIC3_LEFT_OFS
    |=> rdata_out == {third_mic_left_input_left_lvl_out, third_mic_right_input_left_lvl_out})
    else $error("read back differs from stored value");
chk_right_gain_pass: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_RIGHT_GAIN_OFS && wdata_in[APGR_GAIN_MSB:0] <= APGR_GAIN_MAX
    |=> right_gain_out == $past(wdata_in[APGR_GAIN_MSB:0]))
    else $error("right gain code not passed through");
chk_left_gain_sat: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == APGR_LEFT_GAIN_OFS && wdata_in[APGR_GAIN_MSB:0] > APGR_GAIN_MAX
    |=> left_gain_out == APGR_GAIN_MAX)
    else $error("left gain not saturated");

////////////////////////////////////////////////////////////////////////////////

// reset checks run without disable, the reset is their trigger
chk_reset_mutes: assert property (@(posedge clk_in)
    !reset_n_in |=> left_mute_out && right_mute_out)
    else $error("mutes not set by reset");
chk_reset_gains: assert property (@(posedge clk_in)
    !reset_n_in |=> left_gain_out == 7'h00 && right_gain_out == 7'h00)
    else $error("gains not cleared by reset");
chk_reset_levels: assert property (@(posedge clk_in)
    !reset_n_in |=> mix_connect_out == 4'h0 && {third_mic_left_input_left_lvl_out,
    third_mic_right_input_left_lvl_out} == APGR_MIX_RESET)
    else $error("mix levels not off after reset");
chk_stable_left: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(wr_en_in && addr_in == APGR_LEFT_GAIN_OFS) |=> $stable(left_mute_out) && $stable(left_gain_out))
    else $error("left gain changed without a write");
chk_stable_right: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(wr_en_in && addr_in == APGR_RIGHT_GAIN_OFS) |=> $stable(right_mute_out) && $stable(right_gain_out))
    else $error("right gain changed without a write");
chk_stable_mix: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(wr_en_in && (addr_in == APGR_MIC3_LEFT_OFS || addr_in == APGR_MIC3_RIGHT_OFS))
    |=> $stable(mix_connect_out))
    else $error("mix connect changed without a write");
chk_rdata_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !rd_en_in |=> $stable(rdata_out))
    else $error("read data changed without a read");
chk_read_left_reg: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_en_in && addr_in == APGR_LEFT_GAIN_OFS |=> rdata_out == $past(state_reg.left_record_gain_ctrl))
    else $error("left gain read differs from stored value");
chk_read_right_reg: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_en_in && addr_in == APGR_RIGHT_GAIN_OFS |=> rdata_out == $past(state_reg.right_record_gain_ctrl))
    else $error("right gain read differs from stored value");
chk_read_mix_right: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_en_in && addr_in == APGR_MIC3_RIGHT_OFS |=> rdata_out == $past(state_reg.mic_three_to_right_mix))
    else $error("right mix read differs from stored value");
chk_read_unmapped: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rd_en_in && (addr_in < APGR_LEFT_GAIN_OFS || addr_in > APGR_MIC3_RIGHT_OFS)
    |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");

endmodule : apgr_regs
`default_nettype wire

// >>> dv/apgr_host.sv
/* host model for the register port: one strobe per transfer, none for a mix write with an illegal level.
 * assumes one-cycle answers and a registered read data port. */
`timescale 1ns/10ps
`default_nettype none
module apgr_host
    import apgr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output var  logic       wr_en_out,
    output var  logic       rd_en_out,
    output var  logic [7:0] addr_out,
    output var  logic [7:0] wdata_out
);
    function automatic logic apgr_legal(input logic [3:0] lvl);
        apgr_legal = (lvl <= APGR_LEVEL_MAX) || (lvl == APGR_LEVEL_OFF);
    endfunction : apgr_legal
    initial begin
        {wr_en_out, rd_en_out, addr_out, wdata_out} = 18'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        logic mix;
        logic keep;
        mix  = (a == APGR_MIC3_LEFT_OFS) || (a == APGR_MIC3_RIGHT_OFS);
        keep = !(w && mix) || (apgr_legal(d[7:4]) && apgr_legal(d[3:0]));
        @(posedge clk_in);
        {wr_en_out, rd_en_out, addr_out, wdata_out} <= {w && keep, ~w, a, d};
        @(posedge clk_in);
        // idle bus shows inverted values, not stale ones
        {wr_en_out, rd_en_out, addr_out, wdata_out} <= {2'b00, ~a, ~d};
        #1;
        q = rdata_in;
    endtask : xfer
endmodule : apgr_host
`default_nettype wire

// >>> dv/tb_apgr_regs.sv
/* bench for the record gain and mix register bank.
 * assumes the host model drives the register port. */
`timescale 1ns/10ps
`default_nettype none
module tb_apgr_regs import apgr_pkg::*;;
    logic       clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       wr_en;
    logic       rd_en;
    logic       lm;
    logic       rm;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] rb;
    logic [6:0] lg;
    logic [6:0] rg;
    logic [3:0] ll;
    logic [3:0] rl;
    logic [3:0] lr;
    logic [3:0] rr;
    logic [3:0] conn;
    int         err_total = 0;
    int         checked   = 0;
    always #25 clk_in = ~clk_in;
    apgr_regs apgr_regs_i (
        .clk_in                              (clk_in),
        .reset_n_in                          (reset_n_in),
        .wr_en_in                            (wr_en),
        .rd_en_in                            (rd_en),
        .addr_in                             (addr),
        .wdata_in                            (wdata),
        .rdata_out                           (rdata),
        .left_mute_out                       (lm),
        .right_mute_out                      (rm),
        .left_gain_out                       (lg),
        .right_gain_out                      (rg),
        .third_mic_left_input_left_lvl_out   (ll),
        .third_mic_right_input_left_lvl_out  (rl),
        .third_mic_left_input_right_lvl_out  (lr),
        .third_mic_right_input_right_lvl_out (rr),
        .mix_connect_out                     (conn)
    );
    apgr_host apgr_host_i (.clk_in(clk_in), .rdata_in(rdata), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apgr_host_i.xfer(1'b1, a, d, rb);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        apgr_host_i.xfer(1'b0, a, 8'h00, rb);
        chk(rb, exp);
    endtask : rdchk
    // bit 0 left input to left mix, up to bit 3 right input to right mix
    function automatic logic [7:0] exp_conn(input logic [7:0] lmix, input logic [7:0] rmix);
        exp_conn = {4'h0, rmix[3:0] != APGR_LEVEL_OFF, rmix[7:4] != APGR_LEVEL_OFF,
                    lmix[3:0] != APGR_LEVEL_OFF, lmix[7:4] != APGR_LEVEL_OFF};
    endfunction : exp_conn
    task automatic final_report;
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({lm, lg}, APGR_GAIN_RESET);
        chk({rm, rg}, APGR_GAIN_RESET);
        chk({ll, rl}, APGR_MIX_RESET);
        chk({lr, rr}, APGR_MIX_RESET);
        chk({4'h0, conn}, 8'h00);
        chk(rdata, 8'h00);
        rdchk(APGR_LEFT_GAIN_OFS, APGR_GAIN_RESET);
        rdchk(APGR_RIGHT_GAIN_OFS, APGR_GAIN_RESET);
        rdchk(APGR_MIC3_LEFT_OFS, APGR_MIX_RESET);
        rdchk(APGR_MIC3_RIGHT_OFS, APGR_MIX_RESET);
    endtask : t_reset
    task automatic t_gain;
        logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h76, 7'h77, 7'h78, 7'h7F};
        logic [6:0] rc;
        logic [6:0] e;
        logic [6:0] er;
        logic       m;
        foreach (codes[i]) begin
            // right side takes the list backwards so cross wiring shows
            rc = codes[5 - i];
            e  = (codes[i] > APGR_GAIN_MAX) ? APGR_GAIN_MAX : codes[i];
            er = (rc > APGR_GAIN_MAX) ? APGR_GAIN_MAX : rc;
            m  = (i % 2) == 1;
            wr(APGR_LEFT_GAIN_OFS, {m, codes[i]});
            wr(APGR_RIGHT_GAIN_OFS, {~m, rc});
            chk({lm, lg}, {m, e});
            chk({rm, rg}, {~m, er});
            rdchk(APGR_LEFT_GAIN_OFS, {m, codes[i]});
            rdchk(APGR_RIGHT_GAIN_OFS, {~m, rc});
        end
    endtask : t_gain
    task automatic t_mix;
        // legal level codes only, both nibbles
        logic [7:0] pats [10] = '{8'h0F, 8'h17, 8'h26, 8'h35, 8'h48,
                                  8'h53, 8'h62, 8'h71, 8'h80, 8'hF4};
        logic [7:0] sw;
        foreach (pats[i]) begin
            sw = {pats[i][3:0], pats[i][7:4]};
            wr(APGR_MIC3_LEFT_OFS, pats[i]);
            wr(APGR_MIC3_RIGHT_OFS, sw);
            chk({ll, rl}, pats[i]);
            chk({lr, rr}, sw);
            chk({4'h0, conn}, exp_conn(pats[i], sw));
            rdchk(APGR_MIC3_LEFT_OFS, pats[i]);
            rdchk(APGR_MIC3_RIGHT_OFS, sw);
        end
    endtask : t_mix
    task automatic t_unmapped;
        wr(APGR_LEFT_GAIN_OFS, 8'h25);
        wr(APGR_RIGHT_GAIN_OFS, 8'hC3);
        wr(APGR_MIC3_LEFT_OFS, 8'h12);
        wr(APGR_MIC3_RIGHT_OFS, 8'h34);
        wr(8'h13, 8'h00);
        wr(8'h0E, 8'h7F);
        chk(rdata, 8'h4F);
        rdchk(8'h13, 8'h00);
        rdchk(8'h0E, 8'h00);
        chk({lm, lg}, 8'h25);
        chk({rm, rg}, 8'hC3);
        chk({ll, rl}, 8'h12);
        chk({lr, rr}, 8'h34);
        rdchk(APGR_LEFT_GAIN_OFS, 8'h25);
        rdchk(APGR_RIGHT_GAIN_OFS, 8'hC3);
        rdchk(APGR_MIC3_LEFT_OFS, 8'h12);
        rdchk(APGR_MIC3_RIGHT_OFS, 8'h34);
    endtask : t_unmapped
    task automatic t_mid_reset;
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        t_reset();
    endtask : t_mid_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        t_reset();
        t_gain();
        t_mix();
        t_unmapped();
        t_mid_reset();
        final_report();
    end
    initial begin
        #500000;
        err_total++;
        final_report();
    end
endmodule : tb_apgr_regs
`default_nettype wire
